/* hw/asr_pkg.sv */
package asr_pkg;

  // ****************************************
  // Bus and selector widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 8;
  localparam int SRC_LAST = 21;

  // ****************************************
  // Source codes
  // ****************************************
  localparam logic [7:0] SRC_NONE = 8'h00;
  localparam logic [7:0] SRC_SPDIF_RECEIVE = 8'h01;
  localparam logic [7:0] SRC_TEST_HEADER1 = 8'h02;
  localparam logic [7:0] SRC_TEST_HEADER2 = 8'h03;
  localparam logic [7:0] SRC_MINICARD_PORT1 = 8'h04;
  localparam logic [7:0] SRC_MINICARD_PORT2 = 8'h05;
  localparam logic [7:0] SRC_MINICARD_PORT3 = 8'h06;
  localparam logic [7:0] SRC_MINICARD_PORT4 = 8'h07;
  localparam logic [7:0] SRC_MINICARD_PORT5 = 8'h08;
  localparam logic [7:0] SRC_EXPANSION_PORT3 = 8'h09;
  localparam logic [7:0] SRC_EXPANSION_PORT4 = 8'h0a;
  localparam logic [7:0] SRC_EXPANSION_PORT1 = 8'h0b;
  localparam logic [7:0] SRC_EXPANSION_PORT2 = 8'h0c;
  localparam logic [7:0] SRC_USB_STREAM_LOW = 8'h0d;
  localparam logic [7:0] SRC_USB_STREAM_HIGH = 8'h0e;
  localparam logic [7:0] SRC_OPTICAL_MULTICHANNEL = 8'h0f;
  localparam logic [7:0] SRC_ANALOGUE_INPUT = 8'h10;
  localparam logic [7:0] SRC_TDM_STREAM = 8'h11;
  localparam logic [7:0] SRC_TDM_PAIR1 = 8'h12;
  localparam logic [7:0] SRC_TDM_PAIR4 = 8'h15;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_SEL_BASE = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_FMT = 8'h11;
  localparam logic [7:0] REG_STAT = 8'h12;
  localparam logic [7:0] REG_ACT = 8'h13;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam int CTRL_W = 2;
  localparam int CTRL_OPT_BIT = 0;
  localparam int CTRL_MCLK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ****************************************
  // USB streaming format register
  // ****************************************
  localparam int FMT_W = 21;
  localparam int FLD_W = 5;
  localparam int FMT_HIGH_RATE_BIT = 0;
  localparam int FMT_OUT_CH_LSB = 1;
  localparam int FMT_IN_CH_LSB = 6;
  localparam int FMT_OUT_BITS_LSB = 11;
  localparam int FMT_IN_BITS_LSB = 16;
  localparam logic [4:0] FMT_CH_FULL = 5'h10;
  localparam logic [4:0] FMT_CH_HIGH_RATE = 5'h08;
  localparam logic [4:0] FMT_BITS_DEFAULT = 5'h18;
  localparam logic [20:0] FMT_RESET = {FMT_BITS_DEFAULT,
    FMT_BITS_DEFAULT, FMT_CH_FULL, FMT_CH_FULL, 1'b0};
  localparam int STAT_FMT_OK_BIT = 0;
  localparam int STAT_FMT_DEFAULT_BIT = 1;

  // Codes with a source behind them; the two that need setup are gated
  function automatic logic src_usable(input logic [7:0] code,
    input logic opt_ready, input logic mclk_ready);
    logic ok;
    ok = (code != SRC_NONE) && (code <= SRC_TDM_PAIR4);
    if (code == SRC_OPTICAL_MULTICHANNEL)
      ok = opt_ready;
    if (code == SRC_ANALOGUE_INPUT)
      ok = mclk_ready;
    return ok;
  endfunction

  // Streaming format legal for the selected rate
  function automatic logic fmt_legal(input logic [20:0] fmt);
    logic [4:0] oc;
    logic [4:0] ic;
    logic [4:0] ob;
    logic [4:0] ib;
    logic ok;
    oc = fmt[FMT_OUT_CH_LSB +: FLD_W];
    ic = fmt[FMT_IN_CH_LSB +: FLD_W];
    ob = fmt[FMT_OUT_BITS_LSB +: FLD_W];
    ib = fmt[FMT_IN_BITS_LSB +: FLD_W];
    ok = (oc == ic) && (ob == ib);
    if (fmt[FMT_HIGH_RATE_BIT])
      ok = ok && (oc == FMT_CH_HIGH_RATE) && (ob == FMT_BITS_DEFAULT);
    return ok;
  endfunction

endpackage

/* hw/asr_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module asr_sync
  import asr_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // ****************************************
  // Two stage synchroniser
  // ****************************************
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } asr_sync_state_type;

  asr_sync_state_type q;
  asr_sync_state_type d;

  always_comb
  begin
    d = q;
    if (ce)
    begin
      d.meta = din;
      d.safe = q.meta;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.safe;

endmodule
`default_nettype wire

/* hw/asr_sink_mux.sv */
`timescale 1ns/10ps
`default_nettype none
module asr_sink_mux
  import asr_pkg::*;
#(
  parameter int NSRC = SRC_LAST
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [SEL_W-1:0] sel,
  input wire logic opt_ready,
  input wire logic mclk_ready,
  input wire logic [NSRC:1] src_bclk,
  input wire logic [NSRC:1] src_lrclk,
  input wire logic [NSRC:1] src_data,
  output logic bclk_o,
  output logic lrclk_o,
  output logic data_o,
  output logic conn_o
);

  // ****************************************
  // One sink: pick a source, register it
  // ****************************************
  typedef struct packed {
    logic bclk;
    logic lrclk;
    logic data;
    logic conn;
  } asr_mux_state_type;

  asr_mux_state_type q;
  asr_mux_state_type d;
  logic usable;

  // Codes map straight onto source indices, so the odd expansion
  // order and the DSP card aliases need no translation table
  assign usable = src_usable(sel, opt_ready, mclk_ready)
    && (int'(sel) <= NSRC);

  always_comb
  begin
    d = q;
    if (ce)
    begin
      d = '0;
      if (usable)
      begin
        // Clocks travel with the data; a USB source is always master
        d.bclk = src_bclk[sel];
        d.lrclk = src_lrclk[sel];
        d.data = src_data[sel];
        d.conn = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign bclk_o = q.bclk;
  assign lrclk_o = q.lrclk;
  assign data_o = q.data;
  assign conn_o = q.conn;

  // ****************************************
  // Checks
  // ****************************************
  a_none_idle: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_NONE |=> !conn_o && !data_o && !bclk_o)
    else $error("sink not idle with code zero");

  a_unassigned_idle: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel > SRC_TDM_PAIR4 |=> !conn_o && !data_o && !lrclk_o)
    else $error("unassigned code did not idle sink");

  a_spdif_route: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_SPDIF_RECEIVE
    |=> data_o == $past(src_data[SRC_SPDIF_RECEIVE]))
    else $error("spdif data not routed");

  a_usb_clock_master: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_USB_STREAM_HIGH
    |=> bclk_o == $past(src_bclk[SRC_USB_STREAM_HIGH])
    && lrclk_o == $past(src_lrclk[SRC_USB_STREAM_HIGH]))
    else $error("usb clocks not passed through");

  a_usb_low_route: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_USB_STREAM_LOW
    |=> conn_o && data_o == $past(src_data[SRC_USB_STREAM_LOW]))
    else $error("usb low stream not routed");

  a_expansion_order: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_EXPANSION_PORT1
    |=> data_o == $past(src_data[SRC_EXPANSION_PORT1]))
    else $error("expansion port one misrouted");

  a_minicard_route: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_MINICARD_PORT3
    |=> bclk_o == $past(src_bclk[SRC_MINICARD_PORT3]))
    else $error("minicard port three misrouted");

  a_optical_gate: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_OPTICAL_MULTICHANNEL |=> conn_o == $past(opt_ready))
    else $error("optical source gating wrong");

  a_analogue_gate: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_ANALOGUE_INPUT |=> conn_o == $past(mclk_ready))
    else $error("analogue source gating wrong");

  a_tdm_pair: assert property (
    @(posedge clk) disable iff (rst)
    ce && sel == SRC_TDM_PAIR4
    |=> lrclk_o == $past(src_lrclk[SRC_TDM_PAIR4]))
    else $error("tdm pair four misrouted");

  a_frozen_ce: assert property (
    @(posedge clk) disable iff (rst)
    !ce |=> $stable(q))
    else $error("state moved with enable low");

  c_usb_routed: cover property (
    @(posedge clk) disable iff (rst)
    sel == SRC_USB_STREAM_LOW ##1 conn_o);

  c_tdm_stream: cover property (
    @(posedge clk) disable iff (rst)
    sel == SRC_TDM_STREAM ##1 conn_o && data_o);

endmodule
`default_nettype wire

/* hw/asr_top.sv */
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module asr_top
  import asr_pkg::*;
#(
  parameter int NUM_SINKS = 16,
  parameter int NSRC = SRC_LAST
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CLOCK_ENABLE,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic [DATA_W-1:0] WRITE_DATA,
  input wire logic WRITE_STROBE,
  input wire logic READ_STROBE,
  output logic [DATA_W-1:0] READ_DATA,
  input wire logic [NSRC:1] SRC_BCLK,
  input wire logic [NSRC:1] SRC_LRCLK,
  input wire logic [NSRC:1] SRC_DATA,
  output logic [NUM_SINKS-1:0] SINK_BCLK,
  output logic [NUM_SINKS-1:0] SINK_LRCLK,
  output logic [NUM_SINKS-1:0] SINK_DATA,
  output logic [NUM_SINKS-1:0] SINK_CONNECTED
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_SINKS-1:0][SEL_W-1:0] sel;
    logic [CTRL_W-1:0] ctrl;
    logic [FMT_W-1:0] fmt;
    logic [NSRC:1] prev_bclk;
    logic [NSRC:1] act;
    logic [DATA_W-1:0] rdata;
  } asr_top_state_type;

  asr_top_state_type q;
  asr_top_state_type d;

  logic [NSRC:1] bclk_s;
  logic [NSRC:1] lrclk_s;
  logic [NSRC:1] data_s;
  logic [NSRC:1] edges;
  logic fmt_ok;
  logic fmt_default;

  // ****************************************
  // Pin sampling
  // ****************************************
  // Source clocks come from other parties, so every pin is taken
  // through two flops before any routing or edge logic sees it
  asr_sync #(
    .W(3 * NSRC)
  ) u_sync (
    .clk(CLOCK),
    .rst(RESET),
    .ce(CLOCK_ENABLE),
    .din({SRC_DATA, SRC_LRCLK, SRC_BCLK}),
    .dout({data_s, lrclk_s, bclk_s})
  );

  assign edges = bclk_s & ~q.prev_bclk;
  assign fmt_ok = fmt_legal(q.fmt);
  // The default holds for both directions, not only the outbound one
  assign fmt_default = (q.fmt[FMT_OUT_CH_LSB +: FLD_W] == FMT_CH_FULL)
    && (q.fmt[FMT_IN_CH_LSB +: FLD_W] == FMT_CH_FULL)
    && (q.fmt[FMT_OUT_BITS_LSB +: FLD_W] == FMT_BITS_DEFAULT)
    && (q.fmt[FMT_IN_BITS_LSB +: FLD_W] == FMT_BITS_DEFAULT)
    && !q.fmt[FMT_HIGH_RATE_BIT];

  // ****************************************
  // Register access
  // ****************************************
  function automatic logic [DATA_W-1:0] read_word(
    input asr_top_state_type s, input logic [ADDR_W-1:0] a,
    input logic ok, input logic dflt);
    logic [DATA_W-1:0] w;
    w = '0;
    for (int i = 0; i < NUM_SINKS; i++)
    begin
      if (a == REG_SEL_BASE + ADDR_W'(i))
        w[SEL_W-1:0] = s.sel[i];
    end
    case (a)
      REG_CTRL: w[CTRL_W-1:0] = s.ctrl;
      REG_FMT: w[FMT_W-1:0] = s.fmt;
      REG_STAT:
      begin
        w[STAT_FMT_OK_BIT] = ok;
        w[STAT_FMT_DEFAULT_BIT] = dflt;
      end
      REG_ACT: w[NSRC:1] = s.act;
      default: w = w;
    endcase
    return w;
  endfunction

  always_comb
  begin
    d = q;
    if (CLOCK_ENABLE)
    begin
      d.rdata = '0;
      d.prev_bclk = bclk_s;
      d.act = q.act | edges;
      if (WRITE_STROBE)
      begin
        for (int i = 0; i < NUM_SINKS; i++)
        begin
          if (ADDRESS == REG_SEL_BASE + ADDR_W'(i))
            d.sel[i] = WRITE_DATA[SEL_W-1:0];
        end
        case (ADDRESS)
          REG_CTRL: d.ctrl = WRITE_DATA[CTRL_W-1:0];
          REG_FMT: d.fmt = WRITE_DATA[FMT_W-1:0];
          // Clearing activity: a fresh edge in the same cycle wins
          REG_ACT: d.act = (q.act & ~WRITE_DATA[NSRC:1]) | edges;
          default: d.ctrl = q.ctrl;
        endcase
      end
      if (READ_STROBE)
        d.rdata = read_word(q, ADDRESS, fmt_ok, fmt_default);
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      q.sel <= {NUM_SINKS{SEL_RESET}};
      q.ctrl <= CTRL_RESET;
      q.fmt <= FMT_RESET;
      q.prev_bclk <= '0;
      q.act <= '0;
      q.rdata <= '0;
    end
    else
      q <= d;
  end

  assign READ_DATA = q.rdata;

  // ****************************************
  // Per sink routing
  // ****************************************
  // One registered mux per sink; adds one cycle after the synchroniser
  // which is far below a bit clock period at this system rate
  generate
    for (genvar k = 0; k < NUM_SINKS; k++)
    begin : g_sink
      asr_sink_mux #(
        .NSRC(NSRC)
      ) u_mux (
        .clk(CLOCK),
        .rst(RESET),
        .ce(CLOCK_ENABLE),
        .sel(q.sel[k]),
        .opt_ready(q.ctrl[CTRL_OPT_BIT]),
        .mclk_ready(q.ctrl[CTRL_MCLK_BIT]),
        .src_bclk(bclk_s),
        .src_lrclk(lrclk_s),
        .src_data(data_s),
        .bclk_o(SINK_BCLK[k]),
        .lrclk_o(SINK_LRCLK[k]),
        .data_o(SINK_DATA[k]),
        .conn_o(SINK_CONNECTED[k])
      );

      // End to end: gating as seen at the pins, not only inside the mux
      a_unassigned_sink: assert property (
        @(posedge CLOCK) disable iff (RESET)
        CLOCK_ENABLE && q.sel[k] > SRC_TDM_PAIR4
        |=> !SINK_CONNECTED[k] && !SINK_DATA[k] && !SINK_BCLK[k])
        else $error("sink driven by unassigned code");

      a_optical_closed: assert property (
        @(posedge CLOCK) disable iff (RESET)
        CLOCK_ENABLE && q.sel[k] == SRC_OPTICAL_MULTICHANNEL
        && !q.ctrl[CTRL_OPT_BIT] |=> !SINK_CONNECTED[k] && !SINK_DATA[k])
        else $error("optical source routed before setup");

      a_analogue_closed: assert property (
        @(posedge CLOCK) disable iff (RESET)
        CLOCK_ENABLE && q.sel[k] == SRC_ANALOGUE_INPUT
        && !q.ctrl[CTRL_MCLK_BIT] |=> !SINK_CONNECTED[k] && !SINK_DATA[k])
        else $error("analogue source routed without clock");

      a_usb_data_path: assert property (
        @(posedge CLOCK) disable iff (RESET)
        CLOCK_ENABLE && q.sel[k] == SRC_USB_STREAM_HIGH
        |=> SINK_DATA[k] == $past(data_s[SRC_USB_STREAM_HIGH]))
        else $error("usb high stream not at sink pin");
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  a_sel_readback: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && WRITE_STROBE && ADDRESS == REG_SEL_BASE
    ##1 CLOCK_ENABLE && READ_STROBE && ADDRESS == REG_SEL_BASE
    && !WRITE_STROBE
    |=> READ_DATA == {24'h000000, $past(WRITE_DATA[SEL_W-1:0], 2)})
    else $error("selector readback mismatch");

  a_read_only_once: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && !READ_STROBE |=> READ_DATA == 32'h00000000)
    else $error("read data outside its cycle");

  a_fmt_high_rate: assert property (
    @(posedge CLOCK) disable iff (RESET)
    q.fmt[FMT_HIGH_RATE_BIT]
    && q.fmt[FMT_OUT_CH_LSB +: FLD_W] == FMT_CH_FULL |-> !fmt_ok)
    else $error("full width accepted at top rate");

  a_fmt_default: assert property (
    @(posedge CLOCK) disable iff (RESET)
    q.fmt == FMT_RESET |-> fmt_ok && fmt_default)
    else $error("default format not legal");

  a_fmt_mismatch: assert property (
    @(posedge CLOCK) disable iff (RESET)
    q.fmt[FMT_IN_CH_LSB +: FLD_W] != q.fmt[FMT_OUT_CH_LSB +: FLD_W]
    |-> !fmt_ok)
    else $error("mismatched directions accepted");

  a_act_set_wins: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && edges[1] |=> q.act[1])
    else $error("activity edge lost");

  a_sink_latency: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && q.sel[0] == SRC_NONE |=> !SINK_CONNECTED[0])
    else $error("sink zero connected with code zero");

  a_sel_write: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && WRITE_STROBE
    && ADDRESS == REG_SEL_BASE + ADDR_W'(NUM_SINKS - 1)
    |=> q.sel[NUM_SINKS-1] == $past(WRITE_DATA[SEL_W-1:0]))
    else $error("last selector write lost");

  a_ctrl_write: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && WRITE_STROBE && ADDRESS == REG_CTRL
    |=> q.ctrl == $past(WRITE_DATA[CTRL_W-1:0]))
    else $error("control write lost");

  a_ctrl_read: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && READ_STROBE && ADDRESS == REG_CTRL
    |=> READ_DATA == {30'h0, $past(q.ctrl)})
    else $error("control read wrong");

  a_fmt_write: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && WRITE_STROBE && ADDRESS == REG_FMT
    |=> q.fmt == $past(WRITE_DATA[FMT_W-1:0]))
    else $error("format write lost");

  a_unmapped_write: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && WRITE_STROBE && ADDRESS > REG_ACT
    |=> $stable(q.sel) && $stable(q.ctrl) && $stable(q.fmt))
    else $error("unmapped write changed a register");

  a_unmapped_read: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && READ_STROBE && ADDRESS > REG_ACT
    |=> READ_DATA == 32'h00000000)
    else $error("unmapped read not zero");

  a_stat_read: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && READ_STROBE && ADDRESS == REG_STAT
    |=> READ_DATA == {30'h0, $past(fmt_default), $past(fmt_ok)})
    else $error("status read wrong");

  a_fmt_high_ok: assert property (
    @(posedge CLOCK) disable iff (RESET)
    q.fmt == {FMT_BITS_DEFAULT, FMT_BITS_DEFAULT, FMT_CH_HIGH_RATE,
    FMT_CH_HIGH_RATE, 1'b1} |-> fmt_ok && !fmt_default)
    else $error("top rate format refused");

  a_act_clear: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CLOCK_ENABLE && WRITE_STROBE && ADDRESS == REG_ACT
    && WRITE_DATA[1] && !edges[1] |=> !q.act[1])
    else $error("activity bit not cleared");

  c_back_to_back: cover property (
    @(posedge CLOCK) disable iff (RESET)
    WRITE_STROBE ##1 READ_STROBE);

  c_fmt_high_ok: cover property (
    @(posedge CLOCK) disable iff (RESET)
    q.fmt[FMT_HIGH_RATE_BIT] && fmt_ok);

  c_act_clear: cover property (
    @(posedge CLOCK) disable iff (RESET)
    q.act[1] ##1 !q.act[1]);

endmodule
`default_nettype wire

/* dv/asr_source_model.sv */
`timescale 1ns/10ps
`default_nettype none
module asr_source_model
  import asr_pkg::*;
#(
  parameter int NSRC = SRC_LAST
)
(
  input wire logic [NSRC:1] run,
  output logic [NSRC:1] bclk,
  output logic [NSRC:1] lrclk,
  output logic [NSRC:1] data
);
  // ****************************************
  // Serial ports of every source
  // ****************************************
  logic phase;
  logic [31:0] lfsr;
  logic [4:0] slot;

  // Odd offset keeps link edges clear of the system clock edges
  initial
  begin
    phase = 1'b0;
    lfsr = 32'h1;
    slot = 5'h0;
    bclk = {NSRC{1'b0}};
    lrclk = {NSRC{1'b0}};
    data = {NSRC{1'b0}};
    #13;
    forever
    begin
      #200;
      phase = ~phase;
      // Each running port is its own clock master; stopped ones stand low
      bclk = run & {NSRC{phase}};
      if (!phase)
      begin
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        slot = slot + 5'h1;
        if (slot == 5'h0)
          lrclk = lrclk ^ run;
        // Released lines flip each bit, so a stale copy never matches
        data = (run & lfsr[NSRC:1]) | (~run & ~data);
      end
    end
  end
endmodule
`default_nettype wire

/* dv/audio_source_routing_matrix_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module audio_source_routing_matrix_bench
  import asr_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  localparam int TIMEOUT = 6000;
  logic clock;
  logic reset;
  logic clock_enable;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] write_data;
  logic write_strobe;
  logic read_strobe;
  logic [DATA_W-1:0] read_data;
  logic [SRC_LAST:1] src_bclk;
  logic [SRC_LAST:1] src_lrclk;
  logic [SRC_LAST:1] src_data;
  logic [SRC_LAST:1] run;
  logic [15:0] sink_bclk;
  logic [15:0] sink_lrclk;
  logic [15:0] sink_data;
  logic [15:0] sink_connected;
  logic [SRC_LAST:1] hb [0:2];
  logic [SRC_LAST:1] hl [0:2];
  logic [SRC_LAST:1] hd [0:2];
  logic [7:0] sel [0:15];
  logic [1:0] ctrl;
  logic [4:0] fb;
  logic [4:0] fc;
  int mismatches;
  int compares;
  int cycles;
  int seed;

  asr_top #(.NUM_SINKS(16), .NSRC(SRC_LAST)) DUT (.CLOCK(clock),
    .RESET(reset), .CLOCK_ENABLE(clock_enable), .ADDRESS(address),
    .WRITE_DATA(write_data), .WRITE_STROBE(write_strobe),
    .READ_STROBE(read_strobe), .READ_DATA(read_data),
    .SRC_BCLK(src_bclk), .SRC_LRCLK(src_lrclk), .SRC_DATA(src_data),
    .SINK_BCLK(sink_bclk), .SINK_LRCLK(sink_lrclk),
    .SINK_DATA(sink_data), .SINK_CONNECTED(sink_connected));

  asr_source_model #(.NSRC(SRC_LAST)) sources (.run(run),
    .bclk(src_bclk), .lrclk(src_lrclk), .data(src_data));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Pins as sampled two edges back: two sync stages then the mux
  always @(posedge clock)
  begin
    hb <= '{src_bclk, hb[0], hb[1]};
    hl <= '{src_lrclk, hl[0], hl[1]};
    hd <= '{src_data, hd[0], hd[1]};
    cycles <= cycles + 1;
    if (cycles == TIMEOUT)
    begin
      mismatches++;
      summarize();
    end
  end

  // ****************************************
  // Checking
  // ****************************************
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: read %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input int k);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: sink %0d got %b", $time, k, got);
    end
  endtask

  function automatic logic usable(input logic [7:0] c, input logic [1:0] t);
    if (c == 8'h0f)
      return t[0];
    if (c == 8'h10)
      return t[1];
    return c != 8'h00 && c <= 8'h15;
  endfunction

  function automatic logic [31:0] stat_exp(input logic [20:0] f);
    logic ok;
    ok = f[5:1] == f[10:6] && f[15:11] == f[20:16];
    if (f[0])
      ok = ok && f[5:1] == 5'h08 && f[15:11] == 5'h18;
    return {30'h0, f == FMT_RESET, ok};
  endfunction

  task automatic check_sinks();
    logic u;
    int s;
    for (int k = 0; k < 16; k++)
    begin
      u = usable(sel[k], ctrl);
      s = u ? int'(sel[k]) : 1;
      cmp_bit(sink_connected[k], u, k);
      cmp_bit(sink_data[k], u & hd[2][s], k);
      cmp_bit(sink_bclk[k], u & hb[2][s], k);
      cmp_bit(sink_lrclk[k], u & hl[2][s], k);
    end
  endtask

  // ****************************************
  // Register bus
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    cmp_reg(read_data, exp);
  endtask

  // Write then read with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    cmp_reg(read_data, d);
  endtask

  task automatic route(input int n);
    for (int k = 0; k < 16; k++)
      wr(REG_SEL_BASE + 8'(k), {24'h0, sel[k]});
    wr(REG_CTRL, {30'h0, ctrl});
    for (int k = 0; k < 16; k++)
      rd_chk(REG_SEL_BASE + 8'(k), {24'h0, sel[k]});
    repeat (4) @(posedge clock);
    repeat (n)
    begin
      @(negedge clock);
      check_sinks();
    end
  endtask

  task automatic fmt_case(input logic [20:0] f);
    wr(REG_FMT, {11'h0, f});
    rd_chk(REG_FMT, {11'h0, f});
    rd_chk(REG_STAT, stat_exp(f));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 61;
    reset = 1'b1;
    clock_enable = 1'b1;
    address = 8'h00;
    write_data = 32'h0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    run = {SRC_LAST{1'b1}};
    cycles = 0;
    mismatches = 0;
    compares = 0;
    ctrl = 2'h0;
    for (int k = 0; k < 16; k++)
      sel[k] = 8'h00;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(REG_FMT, {11'h0, FMT_RESET});
    rd_chk(REG_STAT, 32'h3);
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'h0);
    rd_chk(8'hff, 32'h0);
    route(10);
    fmt_case({5'h18, 5'h18, 5'h08, 5'h08, 1'b1});
    fmt_case({5'h18, 5'h18, 5'h10, 5'h10, 1'b1});
    fmt_case({5'h10, 5'h10, 5'h08, 5'h08, 1'b1});
    fmt_case({5'h18, 5'h10, 5'h10, 5'h10, 1'b0});
    fmt_case({5'h18, 5'h18, 5'h08, 5'h10, 1'b0});
    repeat (4)
    begin
      fb = 5'($random(seed));
      fc = 5'($random(seed));
      fmt_case({fb, fb, fc, fc, 1'($random(seed))});
    end
    fmt_case(FMT_RESET);
    wr(REG_CTRL, 32'hff);
    rd_chk(REG_CTRL, 32'h3);
    // Edge monitor: quiet sources, clear, then wake one stream
    @(posedge clock);
    run <= {SRC_LAST{1'b0}};
    repeat (20) @(posedge clock);
    wr(REG_ACT, 32'hffffffff);
    rd_chk(REG_ACT, 32'h0);
    run <= SRC_LAST'(1) << 12;
    repeat (20) @(posedge clock);
    rd_chk(REG_ACT, 32'h00002000);
    run <= {SRC_LAST{1'b1}};
    // Codes one to sixteen with both gates shut, then open
    for (int k = 0; k < 16; k++)
      sel[k] = 8'(k + 1);
    route(40);
    ctrl = 2'h3;
    route(40);
    for (int k = 0; k < 16; k++)
      sel[k] = 8'(k + 6);
    ctrl = 2'h1;
    route(40);
    // Writes are ignored while the clock enable is low
    @(posedge clock);
    clock_enable <= 1'b0;
    wr(8'h00, 32'h00000005);
    clock_enable <= 1'b1;
    rd_chk(8'h00, {24'h0, sel[0]});
    wr_rd(8'h00, 32'h0000000d);
    for (int k = 0; k < 16; k++)
      sel[k] = 8'h16 + 8'(k * 15);
    route(20);
    repeat (8)
    begin
      run <= SRC_LAST'($random(seed));
      for (int k = 0; k < 16; k++)
        sel[k] = ($random(seed) & 1) ? 8'($random(seed)) :
          8'({$random(seed)} % 23);
      ctrl = 2'($random(seed));
      route(30);
    end
    summarize();
  end
endmodule
`default_nettype wire
